// [rtl/agr_cmd.sv]
// command interpreter: gain query/force, pin drive/level, radio-data reply
// assumes cmd bytes arrive as one-cycle strobes on clk_sys; the radio-data
// queue head and latest block are given by logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module agr_cmd
    import agr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        powered_up,
    input  wire logic        cmd_valid,
    input  wire logic  [7:0] cmd_byte,
    input  wire logic        cmd_start,
    input  wire logic        resp_rd,
    input  wire logic  [7:0] int_enable,
    input  wire logic        int_pin_mode,
    input  wire logic        clock_in_mode,
    input  wire logic        out_two_int_level,
    input  wire logic  [7:0] group_queue_count,
    input  wire logic [15:0] head_block_b,
    input  wire logic [15:0] head_block_c,
    input  wire logic [15:0] head_block_d,
    input  wire logic [15:0] latest_block_b,
    input  wire logic  [3:0] err_cnt_a,
    input  wire logic  [3:0] err_cnt_b,
    input  wire logic  [3:0] err_cnt_c,
    input  wire logic  [3:0] err_cnt_d,
    input  wire logic  [3:0] uncorr,
    input  wire logic  [3:0] latest_err_cnt_b,
    input  wire logic        latest_uncorr_b,
    input  wire logic        auto_step_valid,
    input  wire logic  [4:0] auto_step,
    input  wire logic  [3:0] int_flags,
    output logic       [7:0] resp_byte,
    output logic             cts,
    output logic             cmd_err,
    output logic             int_out,
    output logic             gain_control_off_q,
    output logic       [4:0] amp_step_q,
    output logic             general_out_one,
    output logic             general_out_two,
    output logic             general_out_three,
    output logic             out_one_oe,
    output logic             out_two_oe,
    output logic             out_three_oe
);
    // ====================================================================
    // command sequencer
    agr_state_t  state_q;
    logic  [7:0] op_q;
    logic  [7:0] arg1_q;
    logic  [7:0] arg2_q;
    logic        cts_q;
    logic        err_q;
    logic  [1:0] busy_q;
    logic        latest_q;
    logic  [3:0] rd_idx_q;
    logic  [3:0] rd_len_q;
    logic  [7:0] resp_q;
    logic        int_q;
    logic  [2:0] drive_en_q;
    logic  [2:0] level_q;
    logic  [2:0] oe_q;
    logic  [2:0] pin_q;
    logic        exec;
    logic        gated_op;
    logic  [1:0] nargs;
    logic  [1:0] ble_a;
    logic  [1:0] ble_b;
    logic  [1:0] ble_c;
    logic  [1:0] ble_d;
    logic  [1:0] ble_lb;
    logic  [7:0] status_byte;
    logic  [7:0] reply_sel;

    always_comb
    begin
        case (op_q)
            AGR_OP_GAIN_FORCE:  nargs = 2'h2;
            AGR_OP_PIN_DRIVE:   nargs = 2'h1;
            AGR_OP_PIN_LEVEL:   nargs = 2'h1;
            AGR_OP_FIFO_STATUS: nargs = 2'h1;
            default:            nargs = 2'h0;
        endcase
    end

    assign gated_op = (op_q == AGR_OP_GAIN_QUERY)
                   || (op_q == AGR_OP_GAIN_FORCE)
                   || (op_q == AGR_OP_PIN_DRIVE)
                   || (op_q == AGR_OP_PIN_LEVEL);
    assign exec = (state_q == AGR_EXEC) && (busy_q == 2'h0);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_q <= AGR_IDLE;
            op_q    <= 8'h00;
            arg1_q  <= 8'h00;
            arg2_q  <= 8'h00;
            busy_q  <= 2'h0;
        end
        else
        begin
            case (state_q)
                AGR_IDLE:
                    if (cmd_valid && cmd_start)
                    begin
                        op_q   <= cmd_byte;
                        arg1_q <= 8'h00;
                        arg2_q <= 8'h00;
                        busy_q <= 2'(AGR_CMD_CYCLES - 1);
                        state_q <= AGR_ARG1;
                    end
                AGR_ARG1:
                    if (nargs == 2'h0)
                        state_q <= AGR_EXEC;
                    else if (cmd_valid)
                    begin
                        arg1_q  <= cmd_byte;
                        state_q <= (nargs == 2'h2) ? AGR_ARG2 : AGR_EXEC;
                    end
                AGR_ARG2:
                    if (cmd_valid)
                    begin
                        arg2_q  <= cmd_byte;
                        state_q <= AGR_EXEC;
                    end
                AGR_EXEC:
                    if (busy_q != 2'h0)
                        busy_q <= busy_q - 2'h1;
                    else
                        state_q <= AGR_IDLE;
                default:
                    state_q <= AGR_IDLE;
            endcase
        end
    end

    // ====================================================================
    // clear-to-send and error flags
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            cts_q <= 1'b1;
        else if (cmd_valid && cmd_start && state_q == AGR_IDLE)
            cts_q <= 1'b0;
        else if (exec)
            cts_q <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            err_q <= 1'b0;
        else if (exec)
            err_q <= gated_op && !powered_up;
    end

    // ====================================================================
    // gain control
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            gain_control_off_q <= 1'b0;
            amp_step_q         <= AGR_STEP_RST;
        end
        else if (exec && op_q == AGR_OP_GAIN_FORCE && powered_up)
        begin
            gain_control_off_q <= arg1_q[AGR_ARG_GAIN_OFF_BIT];
            if (arg1_q[AGR_ARG_GAIN_OFF_BIT])
                amp_step_q <= (arg2_q[AGR_STEP_W-1:0] > AGR_STEP_MAX)
                            ? AGR_STEP_MAX : arg2_q[AGR_STEP_W-1:0];
        end
        else if (!gain_control_off_q && auto_step_valid)
            amp_step_q <= auto_step;
    end

    // ====================================================================
    // general outputs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            drive_en_q <= 3'h0;
            level_q    <= 3'h0;
        end
        else if (exec && powered_up)
        begin
            if (op_q == AGR_OP_PIN_DRIVE)
                drive_en_q <= arg1_q[3:1];
            if (op_q == AGR_OP_PIN_LEVEL)
                level_q <= arg1_q[3:1];
        end
    end

    // interrupt pin and clock input functions win over drive settings
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            oe_q  <= 3'h0;
            pin_q <= 3'h0;
        end
        else
        begin
            oe_q[0]  <= drive_en_q[0];
            pin_q[0] <= level_q[0];
            oe_q[1]  <= int_pin_mode ? 1'b1 : drive_en_q[1];
            pin_q[1] <= int_pin_mode ? out_two_int_level : level_q[1];
            oe_q[2]  <= clock_in_mode ? 1'b0 : drive_en_q[2];
            pin_q[2] <= clock_in_mode ? 1'b0 : level_q[2];
        end
    end

    // ====================================================================
    // reply bytes
    agr_ble_enc u_ble_a (.err_count(err_cnt_a), .uncorrectable(uncorr[0]),
                         .level(ble_a));
    agr_ble_enc u_ble_b (.err_count(err_cnt_b), .uncorrectable(uncorr[1]),
                         .level(ble_b));
    agr_ble_enc u_ble_c (.err_count(err_cnt_c), .uncorrectable(uncorr[2]),
                         .level(ble_c));
    agr_ble_enc u_ble_d (.err_count(err_cnt_d), .uncorrectable(uncorr[3]),
                         .level(ble_d));
    agr_ble_enc u_ble_lb (.err_count(latest_err_cnt_b),
                          .uncorrectable(latest_uncorr_b), .level(ble_lb));

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[AGR_ST_CTS] = cts_q;
        status_byte[AGR_ST_ERR] = err_q;
        status_byte[AGR_ST_SQ]  = int_flags[3];
        status_byte[AGR_ST_RD]  = int_flags[2];
        status_byte[AGR_ST_AQ]  = int_flags[1];
        status_byte[AGR_ST_STC] = int_flags[0];
    end

    always_comb
    begin
        reply_sel = 8'h00;
        if (rd_idx_q == 4'h0)
            reply_sel = status_byte;
        else if (op_q == AGR_OP_GAIN_QUERY)
            case (rd_idx_q)
                4'h1: reply_sel = {7'h00, gain_control_off_q};
                4'h2: reply_sel = {3'h0, amp_step_q};
                default: reply_sel = 8'h00;
            endcase
        else if (op_q == AGR_OP_FIFO_STATUS)
            case (rd_idx_q)
                4'h3: reply_sel = group_queue_count;
                4'h6: reply_sel = latest_q ? latest_block_b[15:8]
                                           : head_block_b[15:8];
                4'h7: reply_sel = latest_q ? latest_block_b[7:0]
                                           : head_block_b[7:0];
                4'h8: reply_sel = head_block_c[15:8];
                4'h9: reply_sel = head_block_c[7:0];
                4'ha: reply_sel = head_block_d[15:8];
                4'hb: reply_sel = head_block_d[7:0];
                4'hc: reply_sel = {ble_a, latest_q ? ble_lb : ble_b,
                                   ble_c, ble_d};
                default: reply_sel = 8'h00;
            endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rd_idx_q <= 4'h0;
            rd_len_q <= 4'h0;
            latest_q <= 1'b0;
        end
        else if (exec)
        begin
            rd_idx_q <= 4'h0;
            latest_q <= arg1_q[AGR_ARG_LATEST_BIT];
            if (op_q == AGR_OP_GAIN_QUERY && powered_up)
                rd_len_q <= AGR_RB_GQ_LEN;
            else if (op_q == AGR_OP_FIFO_STATUS)
                rd_len_q <= AGR_RB_FS_LEN;
            else
                rd_len_q <= 4'h0;
        end
        else if (resp_rd && rd_idx_q < rd_len_q)
            rd_idx_q <= rd_idx_q + 4'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            resp_q <= 8'h00;
        else
            resp_q <= reply_sel;
    end

    // all status byte bits, CTS and ERR included, gated by the enable mask onto the interrupt
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            int_q <= 1'b0;
        else
            int_q <= |(status_byte & int_enable);
    end

    assign resp_byte         = resp_q;
    assign cts               = cts_q;
    assign cmd_err           = err_q;
    assign int_out           = int_q;
    assign general_out_one   = pin_q[0];
    assign general_out_two   = pin_q[1];
    assign general_out_three = pin_q[2];
    assign out_one_oe        = oe_q[0];
    assign out_two_oe        = oe_q[1];
    assign out_three_oe      = oe_q[2];
endmodule
`default_nettype wire

// [rtl/agr_pkg.sv]
// package for the gain, pin and radio-data response command block
// assumes a byte-wide command stream already deframed from the serial bus
package agr_pkg;
    localparam logic [7:0] AGR_OP_FIFO_STATUS = 8'h24;
    localparam logic [7:0] AGR_OP_GAIN_QUERY  = 8'h27;
    localparam logic [7:0] AGR_OP_GAIN_FORCE  = 8'h28;
    localparam logic [7:0] AGR_OP_PIN_DRIVE   = 8'h80;
    localparam logic [7:0] AGR_OP_PIN_LEVEL   = 8'h81;
    // argument bit positions
    localparam int AGR_ARG_LATEST_BIT = 2;
    localparam int AGR_ARG_GAIN_OFF_BIT = 0;
    localparam int AGR_STEP_W = 5;
    localparam logic [4:0] AGR_STEP_MAX = 5'h1a;
    localparam logic [4:0] AGR_STEP_RST = 5'h00;
    // status byte bit positions
    localparam int AGR_ST_CTS = 7;
    localparam int AGR_ST_ERR = 6;
    localparam int AGR_ST_SQ  = 3;
    localparam int AGR_ST_RD  = 2;
    localparam int AGR_ST_AQ  = 1;
    localparam int AGR_ST_STC = 0;
    // reply byte indices (status byte is index 0)
    localparam logic [3:0] AGR_RB_GQ_LEN = 4'h2;
    localparam logic [3:0] AGR_RB_FS_LEN = 4'hc;
    localparam logic [1:0] AGR_BLE_NONE  = 2'h0;
    localparam logic [1:0] AGR_BLE_SMALL = 2'h1;
    localparam logic [1:0] AGR_BLE_LARGE = 2'h2;
    localparam logic [1:0] AGR_BLE_BAD   = 2'h3;
    localparam logic [3:0] AGR_SMALL_MAX = 4'h2;
    localparam logic [3:0] AGR_LARGE_MAX = 4'h5;
    localparam int AGR_CMD_CYCLES = 2;
    typedef enum logic [1:0]
    {
        AGR_IDLE = 2'b00,
        AGR_ARG1 = 2'b01,
        AGR_ARG2 = 2'b11,
        AGR_EXEC = 2'b10
    } agr_state_t;
endpackage

// [rtl/agr_ble_enc.sv]
// maps a count of corrected bit errors to a two-bit error level
// assumes the decoder flags an uncorrectable block separately
`timescale 1ns/100ps
`default_nettype none
module agr_ble_enc
    import agr_pkg::*;
(
    input  wire logic [3:0] err_count,
    input  wire logic       uncorrectable,
    output logic      [1:0] level
);
    always_comb
    begin
        if (uncorrectable || err_count > AGR_LARGE_MAX)
            level = AGR_BLE_BAD;
        else if (err_count > AGR_SMALL_MAX)
            level = AGR_BLE_LARGE;
        else if (err_count != 4'h0)
            level = AGR_BLE_SMALL;
        else
            level = AGR_BLE_NONE;
    end
endmodule
`default_nettype wire

// [bench/agr_cmd_monitor.sv]
// concurrent checks on the command block ports
// assumes one clock, clk_sys, and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module agr_cmd_monitor
    import agr_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       powered_up,
    input wire logic       cmd_valid,
    input wire logic       cmd_start,
    input wire logic [7:0] cmd_byte,
    input wire logic       int_pin_mode,
    input wire logic       clock_in_mode,
    input wire logic [7:0] int_enable,
    input wire logic       cts,
    input wire logic       cmd_err,
    input wire logic       int_out,
    input wire logic       gain_control_off_q,
    input wire logic [4:0] amp_step_q,
    input wire logic       out_two_oe,
    input wire logic       out_three_oe,
    input wire logic       general_out_three
);
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_op;
        cmd_valid && cmd_start && cts;
    endsequence
    sequence s_back;
        ##[1:8] cts;
    endsequence
    property p_cts_low;
        (s_op and powered_up) |=> !cts;
    endproperty
    property p_cts_back;
        $fell(cts) |-> s_back;
    endproperty
    property p_two_int;
        int_pin_mode ##1 int_pin_mode |-> out_two_oe;
    endproperty
    property p_three_clk;
        clock_in_mode ##1 clock_in_mode
            |-> !out_three_oe && !general_out_three;
    endproperty
    property p_step_max;
        amp_step_q <= AGR_STEP_MAX;
    endproperty
    property p_step_hold;
        gain_control_off_q && cts |=> $stable(amp_step_q);
    endproperty
    property p_refuse;
        (s_op and !powered_up and (cmd_byte == AGR_OP_PIN_DRIVE))
            |-> ##[1:8] cmd_err;
    endproperty
    property p_int_on;
        (cts && int_enable[AGR_ST_CTS]) ##1 (cts && int_enable[AGR_ST_CTS])
            |-> int_out;
    endproperty
    property p_int_off;
        (int_enable == 8'h00) ##1 (int_enable == 8'h00) |-> !int_out;
    endproperty
    a_cts_low: assert property (p_cts_low)
        else $error("cts stayed high");
    a_cts_back: assert property (p_cts_back)
        else $error("cts late");
    a_two_int: assert property (p_two_int)
        else $error("out two not on");
    a_three_clk: assert property (p_three_clk)
        else $error("out three on");
    a_step_max: assert property (p_step_max)
        else $error("step over max");
    a_step_hold: assert property (p_step_hold)
        else $error("step moved");
    a_refuse: assert property (p_refuse)
        else $error("no error flag");
    a_int_on: assert property (p_int_on)
        else $error("int missing");
    a_int_off: assert property (p_int_off)
        else $error("int spurious");
endmodule
bind agr_cmd agr_cmd_monitor u_mon
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .powered_up(powered_up),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_byte(cmd_byte),
    .int_pin_mode(int_pin_mode), .clock_in_mode(clock_in_mode),
    .int_enable(int_enable), .cts(cts), .cmd_err(cmd_err),
    .int_out(int_out), .gain_control_off_q(gain_control_off_q),
    .amp_step_q(amp_step_q), .out_two_oe(out_two_oe),
    .out_three_oe(out_three_oe), .general_out_three(general_out_three)
);
`default_nettype wire

// [bench/agr_host_model.sv]
// system controller model: sends commands and reads reply bytes
// assumes the block samples on the rising edge; this drives on the falling
`timescale 1ns/100ps
`default_nettype none
module agr_host_model
(
    input  wire logic       clk_sys,
    input  wire logic       cts,
    input  wire logic [7:0] resp_byte,
    output var logic        cmd_valid,
    output var logic        cmd_start,
    output var logic  [7:0] cmd_byte,
    output var logic        resp_rd
);
    // ==========================================================
    // command and reply tasks
    initial
    begin
        cmd_valid = 1'b0;
        cmd_start = 1'b0;
        cmd_byte  = 8'h00;
        resp_rd   = 1'b0;
    end
    // caller drives powered_up; gain and pin commands sent while it is low only set the error flag
    task automatic send(input logic [7:0] op, input int n,
                        input logic [7:0] a1, input logic [7:0] a2);
        int k;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_start = 1'b1;
        cmd_byte  = op;
        for (k = 0; k < n; k++)
        begin
            @(negedge clk_sys);
            cmd_start = 1'b0;
            cmd_byte  = (k == 0) ? a1 : a2;
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_start = 1'b0;
        // released bus shows the inverse, not a stale copy
        cmd_byte  = ~cmd_byte;
        // a hang here is left to the bench watchdog, which counts it
        while (cts !== 1'b1)
            @(negedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic get(output logic [7:0] b);
        @(negedge clk_sys);
        resp_rd = 1'b1;
        @(negedge clk_sys);
        resp_rd = 1'b0;
        @(negedge clk_sys);
        b = resp_byte;
    endtask
endmodule
`default_nettype wire

// [bench/agr_cmd_tb.sv]
// testbench for the command block, driven through the controller model
// assumes inputs change on the falling edge of clk_sys
`timescale 1ns/100ps
`default_nettype none
module agr_cmd_tb;
    import agr_pkg::*;
    logic clk_sys, sys_rst, powered_up, int_pin_mode, clock_in_mode;
    logic cmd_valid, cmd_start, resp_rd, cts, cmd_err, int_out, goff;
    logic o1, o2, o3, e1, e2, e3, av;
    logic [7:0] int_enable, gq, cmd_byte, resp_byte, rb;
    logic [7:0] ex [1:12];
    logic [15:0] hb, hc, hd, lb;
    logic [3:0] int_flags, uncorr, ecb, ecc, ecl;
    logic [4:0] step, astep;
    int n_fail, tests_run, i;
    // ==========================================================
    // design, controller model, checks
    agr_cmd DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .powered_up(powered_up), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_start(cmd_start), .resp_rd(resp_rd),
        .int_enable(int_enable), .int_pin_mode(int_pin_mode),
        .clock_in_mode(clock_in_mode), .out_two_int_level(1'b1),
        .group_queue_count(gq), .head_block_b(hb), .head_block_c(hc),
        .head_block_d(hd), .latest_block_b(lb), .err_cnt_a(ecl),
        .err_cnt_b(ecb), .err_cnt_c(ecc), .err_cnt_d(ecb),
        .uncorr(uncorr), .latest_err_cnt_b(ecl), .latest_uncorr_b(1'b0),
        .auto_step_valid(av), .auto_step(astep), .int_flags(int_flags),
        .resp_byte(resp_byte), .cts(cts), .cmd_err(cmd_err),
        .int_out(int_out), .gain_control_off_q(goff), .amp_step_q(step),
        .general_out_one(o1), .general_out_two(o2), .general_out_three(o3),
        .out_one_oe(e1), .out_two_oe(e2), .out_three_oe(e3));
    agr_host_model H (.clk_sys(clk_sys), .cts(cts), .resp_byte(resp_byte),
        .cmd_valid(cmd_valid), .cmd_start(cmd_start),
        .cmd_byte(cmd_byte), .resp_rd(resp_rd));
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic fifo(input logic [7:0] a, input int last);
        H.send(AGR_OP_FIFO_STATUS, 1, a, 8'h00);
        for (i = 1; i <= last; i++)
        begin
            H.get(rb);
            chk("fifo byte", ex[i], rb);
        end
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400000;
        n_fail++;
        print_verdict;
    end
    initial
    begin
        n_fail = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        powered_up = 1'b1;
        int_pin_mode = 1'b0;
        clock_in_mode = 1'b0;
        int_enable = 8'h00;
        int_flags = 4'h5;
        gq = 8'h07;
        hb = 16'h1234;
        hc = 16'h5678;
        hd = 16'h9abc;
        lb = 16'hdef0;
        ecb = 4'h2;
        ecc = 4'h5;
        ecl = 4'h3;
        uncorr = 4'h8;
        // automatic loop keeps offering a step; a forced step must ignore it
        av = 1'b1;
        astep = 5'h0d;
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("oe", 8'h00, {5'h0, e3, e2, e1});
        chk("level", 8'h00, {5'h0, o3, o2, o1});
        H.send(AGR_OP_PIN_DRIVE, 1, 8'h0e, 8'h00);
        chk("cts", 8'h01, {7'h0, cts});
        chk("oe", 8'h07, {5'h0, e3, e2, e1});
        H.send(AGR_OP_PIN_LEVEL, 1, 8'h0a, 8'h00);
        chk("level", 8'h05, {5'h0, o3, o2, o1});
        powered_up = 1'b0;
        H.send(AGR_OP_PIN_DRIVE, 1, 8'h00, 8'h00);
        H.send(AGR_OP_GAIN_FORCE, 2, 8'h01, 8'h09);
        chk("err", 8'h01, {7'h0, cmd_err});
        chk("oe", 8'h07, {5'h0, e3, e2, e1});
        chk("step", 8'h0d, {3'h0, step});
        chk("off", 8'h00, {7'h0, goff});
        powered_up = 1'b1;
        clock_in_mode = 1'b1;
        H.send(AGR_OP_PIN_DRIVE, 1, 8'h0e, 8'h00);
        chk("oe", 8'h03, {5'h0, e3, e2, e1});
        chk("err", 8'h00, {7'h0, cmd_err});
        clock_in_mode = 1'b0;
        int_pin_mode = 1'b1;
        H.send(AGR_OP_PIN_DRIVE, 1, 8'h00, 8'h00);
        chk("oe", 8'h02, {5'h0, e3, e2, e1});
        chk("level", 8'h07, {5'h0, o3, o2, o1});
        int_pin_mode = 1'b0;
        foreach (ex[i])
            ex[i] = {3'h0, i[0] ? AGR_STEP_RST : AGR_STEP_MAX};
        for (i = 1; i <= 2; i++)
        begin
            // the second pass asks above the top step and expects the clamp
            H.send(AGR_OP_GAIN_FORCE, 2, 8'h01, i[0] ? ex[i] : 8'h1f);
            chk("step", ex[i], {3'h0, step});
            H.send(AGR_OP_GAIN_QUERY, 0, 8'h00, 8'h00);
            chk("status", 8'h85, resp_byte);
            H.get(rb);
            chk("off", 8'h01, rb);
            H.get(rb);
            chk("step", ex[i], rb);
        end
        H.send(AGR_OP_GAIN_FORCE, 2, 8'h00, 8'h03);
        H.send(AGR_OP_GAIN_QUERY, 0, 8'h00, 8'h00);
        chk("off", 8'h00, {7'h0, goff});
        H.get(rb);
        chk("off", 8'h00, rb);
        H.get(rb);
        chk("step", 8'h0d, rb);
        foreach (ex[i])
            ex[i] = 8'h00;
        ex[3] = gq;
        ex[6] = hb[15:8];
        ex[7] = hb[7:0];
        ex[8] = hc[15:8];
        ex[9] = hc[7:0];
        ex[10] = hd[15:8];
        ex[11] = hd[7:0];
        // levels a=2, b=1, c=2, d=3 from the counts driven above
        ex[12] = 8'h9b;
        fifo(8'h00, 12);
        ex[6] = lb[15:8];
        ex[7] = lb[7:0];
        // latest block b carries three errors, level 2
        ex[12] = 8'hab;
        fifo(8'h04, 12);
        int_enable = 8'h80;
        repeat (3) @(negedge clk_sys);
        chk("int", 8'h01, {7'h0, int_out});
        int_enable = 8'h00;
        repeat (3) @(negedge clk_sys);
        chk("int", 8'h00, {7'h0, int_out});
        H.send(AGR_OP_PIN_DRIVE, 1, 8'h0e, 8'h00);
        chk("oe", 8'h07, {5'h0, e3, e2, e1});
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("oe", 8'h00, {5'h0, e3, e2, e1});
        chk("level", 8'h00, {5'h0, o3, o2, o1});
        chk("cts", 8'h01, {7'h0, cts});
        print_verdict;
    end
endmodule
`default_nettype wire
